// ===== shared/eel_pkg.sv
/*
 * Constants for the edge event line controller: line counts, register
 * offsets, field layout and reset values.
 * Assumes a byte-addressed Avalon-MM slave with 32-bit data.
 */
package eel_pkg;
  localparam int NUM_LINES = 19;
  localparam int NUM_EXT = 16;
  localparam int NUM_PINS = 51;
  localparam int SEL_W = 6;
  localparam int SEL_FIELD_W = 8;
  localparam int SEL_PER_WORD = 4;
  localparam int ADDR_W = 8;
  localparam int LINE_SUPPLY = 16;
  localparam int LINE_RTC = 17;
  localparam int LINE_USB = 18;

  localparam logic [ADDR_W-1:0] OFF_RISE = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_FALL = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_EVT_EN = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_PEND = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_SEL0 = 8'h20;
  localparam logic [ADDR_W-1:0] WORD_BYTES = 8'h04;

  localparam logic [31:0] RST_TRIG = 32'h0000_0000;
  localparam logic [31:0] RST_MASK = 32'h0000_0000;
  localparam logic [SEL_W-1:0] RST_SEL = 6'h00;
endpackage : eel_pkg

// ===== hw/eel_edge_cell.sv
/*
 * One edge detector line. Edges are caught by toggle flops clocked by the
 * line itself, so a pulse shorter than a bus clock period, or one arriving
 * while the bus clock is stopped, is still recorded.
 * Assumes the enable inputs change only while the line is quiet.
 */
`timescale 1ns/100ps
module eel_edge_cell (
  input wire logic sysClk,
  input wire logic rst,
  input wire logic lineIn,
  input wire logic riseEn,
  input wire logic fallEn,
  output logic edgeDet
);
  logic riseTogQ;
  logic fallTogQ;
  logic [2:0] riseSyncQ;
  logic [2:0] fallSyncQ;

  // Capture ahead of the bus clock domain
  always_ff @(posedge lineIn or posedge rst) begin
    if (rst) begin
      riseTogQ <= 1'b0;
    end else if (riseEn) begin
      riseTogQ <= ~riseTogQ;
    end
  end

  always_ff @(negedge lineIn or posedge rst) begin
    if (rst) begin
      fallTogQ <= 1'b0;
    end else if (fallEn) begin
      fallTogQ <= ~fallTogQ;
    end
  end

  // Toggles cross by two flops; the third only remembers the last level
  always_ff @(posedge sysClk or posedge rst) begin
    if (rst) begin
      riseSyncQ <= 3'h0;
      fallSyncQ <= 3'h0;
    end else begin
      riseSyncQ <= {riseSyncQ[1:0], riseTogQ};
      fallSyncQ <= {fallSyncQ[1:0], fallTogQ};
    end
  end

  assign edgeDet = (riseSyncQ[1] ^ riseSyncQ[2]) | (fallSyncQ[1] ^ fallSyncQ[2]);
endmodule : eel_edge_cell

// ===== hw/eel_controller.sv
/*
 * Edge event line controller: pin multiplexer, per-line edge detection,
 * pending record, interrupt and event outputs, Avalon-MM register slave.
 * Assumes synchronous bus signals on sysClk and a master that holds each
 * request until it sees waitrequest low.
 */
`timescale 1ns/100ps

// Overview of operation
// - Nineteen independent edge lines each raise an interrupt or event request.
// - Each line selects rising, falling or both edges separately.
// - Each line has its own mask, blocking only that line.
// - A per-line pending bit records a detected qualifying edge.
// - Pulses shorter than a bus clock period are caught before synchronisation.
// - Sixteen pin lines each pick one of up to fifty-one pins.
// - Lines 16 to 18 come from supply monitor, clock alarm, bus wakeup.
// - Edge capture works with the system clock stopped, for wakeup.
module eel_controller #(
  parameter int NUM_LINES = eel_pkg::NUM_LINES,
  parameter int NUM_EXT = eel_pkg::NUM_EXT,
  parameter int NUM_PINS = eel_pkg::NUM_PINS
) (
  input wire logic sysClk,
  input wire logic rst,
  input wire logic [NUM_PINS-1:0] gpioPins,
  input wire logic supplyLevelMonitor,
  input wire logic rtcAlarm,
  input wire logic usbWakeup,
  input wire logic [eel_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irqOut,
  output logic [NUM_LINES-1:0] lineIrq,
  output logic [NUM_LINES-1:0] eventPulse
);
  localparam int SELW = eel_pkg::SEL_W;

  if (NUM_LINES != NUM_EXT + 3 || NUM_LINES > 32 || NUM_PINS > (1 << SELW)
      || NUM_EXT > 4 * eel_pkg::SEL_PER_WORD) begin : g_check
    $error("eel_controller: unsupported line or pin count");
  end

  logic [NUM_LINES-1:0] riseEnQ;
  logic [NUM_LINES-1:0] fallEnQ;
  logic [NUM_LINES-1:0] irqEnQ;
  logic [NUM_LINES-1:0] evtEnQ;
  logic [NUM_LINES-1:0] pendingQ;
  logic [SELW-1:0] pinSelQ [NUM_EXT];
  logic [NUM_LINES-1:0] lineSrc;
  logic [NUM_LINES-1:0] edgeDet;
  logic [31:0] readDataQ;
  logic waitReqQ;
  logic irqQ;
  logic [NUM_LINES-1:0] lineIrqQ;
  logic [NUM_LINES-1:0] eventQ;
  logic [31:0] rdMux;
  logic wrAcc;
  logic rdAcc;
  logic [31:0] beMask;

  assign wrAcc = write && !waitReqQ;
  assign rdAcc = read && !waitReqQ;
  assign beMask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}},
                   {8{byteenable[0]}}};

  function automatic logic [NUM_LINES-1:0] merge(input logic [NUM_LINES-1:0] old);
    merge = (old & ~beMask[NUM_LINES-1:0]) | (writedata[NUM_LINES-1:0] & beMask[NUM_LINES-1:0]);
  endfunction : merge

  // Internal sources on the top lines
  assign lineSrc[eel_pkg::LINE_SUPPLY] = supplyLevelMonitor;
  assign lineSrc[eel_pkg::LINE_RTC] = rtcAlarm;
  assign lineSrc[eel_pkg::LINE_USB] = usbWakeup;

  for (genvar j = 0; j < NUM_EXT; j++) begin : g_ext
    localparam int LANE = j % eel_pkg::SEL_PER_WORD;
    localparam logic [eel_pkg::ADDR_W-1:0] SEL_OFF = eel_pkg::OFF_SEL0
        + eel_pkg::WORD_BYTES * eel_pkg::ADDR_W'(j / eel_pkg::SEL_PER_WORD);
    always_ff @(posedge sysClk or posedge rst) begin
      if (rst) begin
        pinSelQ[j] <= eel_pkg::RST_SEL;
      end else if (wrAcc && address == SEL_OFF && byteenable[LANE]) begin
        pinSelQ[j] <= writedata[eel_pkg::SEL_FIELD_W*LANE +: SELW];
      end
    end
    // Pin mux; out-of-range selects read low. Reselecting may fake an edge.
    assign lineSrc[j] = (32'(pinSelQ[j]) < NUM_PINS) ? gpioPins[pinSelQ[j]] : 1'b0;
  end

  for (genvar i = 0; i < NUM_LINES; i++) begin : g_line
    eel_edge_cell u_cell (
      .sysClk(sysClk),
      .rst(rst),
      .lineIn(lineSrc[i]),
      .riseEn(riseEnQ[i]),
      .fallEn(fallEnQ[i]),
      .edgeDet(edgeDet[i])
    );
  end

  // Configuration registers
  always_ff @(posedge sysClk or posedge rst) begin
    if (rst) begin
      riseEnQ <= eel_pkg::RST_TRIG[NUM_LINES-1:0];
      fallEnQ <= eel_pkg::RST_TRIG[NUM_LINES-1:0];
      irqEnQ <= eel_pkg::RST_MASK[NUM_LINES-1:0];
      evtEnQ <= eel_pkg::RST_MASK[NUM_LINES-1:0];
    end else if (wrAcc) begin
      if (address == eel_pkg::OFF_RISE) riseEnQ <= merge(riseEnQ);
      if (address == eel_pkg::OFF_FALL) fallEnQ <= merge(fallEnQ);
      if (address == eel_pkg::OFF_IRQ_EN) irqEnQ <= merge(irqEnQ);
      if (address == eel_pkg::OFF_EVT_EN) evtEnQ <= merge(evtEnQ);
    end
  end

  // Read clears only what was returned, so an edge landing mid-read survives
  always_ff @(posedge sysClk or posedge rst) begin
    if (rst) begin
      pendingQ <= eel_pkg::RST_MASK[NUM_LINES-1:0];
    end else if (rdAcc && address == eel_pkg::OFF_PEND) begin
      pendingQ <= (pendingQ & ~readDataQ[NUM_LINES-1:0]) | edgeDet;
    end else begin
      pendingQ <= pendingQ | edgeDet;
    end
  end

  always_ff @(posedge sysClk or posedge rst) begin
    if (rst) begin
      irqQ <= 1'b0;
      lineIrqQ <= '0;
      eventQ <= '0;
    end else begin
      lineIrqQ <= pendingQ & irqEnQ;
      irqQ <= |(pendingQ & irqEnQ);
      eventQ <= edgeDet & evtEnQ;
    end
  end

  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (address)
      eel_pkg::OFF_RISE: rdMux[NUM_LINES-1:0] = riseEnQ;
      eel_pkg::OFF_FALL: rdMux[NUM_LINES-1:0] = fallEnQ;
      eel_pkg::OFF_IRQ_EN: rdMux[NUM_LINES-1:0] = irqEnQ;
      eel_pkg::OFF_EVT_EN: rdMux[NUM_LINES-1:0] = evtEnQ;
      eel_pkg::OFF_PEND: rdMux[NUM_LINES-1:0] = pendingQ;
      default: begin
        for (int k = 0; k < NUM_EXT; k++) begin
          if (address == eel_pkg::OFF_SEL0
              + eel_pkg::WORD_BYTES * eel_pkg::ADDR_W'(k / eel_pkg::SEL_PER_WORD)) begin
            rdMux[eel_pkg::SEL_FIELD_W*(k % eel_pkg::SEL_PER_WORD) +: SELW] = pinSelQ[k];
          end
        end
      end
    endcase
  end

  // Fixed one-cycle wait: data loaded on the edge that drops waitrequest
  always_ff @(posedge sysClk or posedge rst) begin
    if (rst) begin
      waitReqQ <= 1'b1;
      readDataQ <= 32'h0000_0000;
    end else begin
      waitReqQ <= !((read || write) && waitReqQ);
      if (read && waitReqQ) readDataQ <= rdMux;
    end
  end

  assign readdata = readDataQ;
  assign waitrequest = waitReqQ;
  assign irqOut = irqQ;
  assign lineIrq = lineIrqQ;
  assign eventPulse = eventQ;

  pend_set_a: assert property (@(posedge sysClk) disable iff (rst)
    (edgeDet != '0) |=> ((pendingQ & $past(edgeDet)) == $past(edgeDet)))
    else $error("detected edge did not set pending");
  pend_hold_a: assert property (@(posedge sysClk) disable iff (rst)
    !(rdAcc && address == eel_pkg::OFF_PEND) |=> ((pendingQ & $past(pendingQ)) == $past(pendingQ)))
    else $error("pending dropped without a pending read");
  irq_cause_a: assert property (@(posedge sysClk) disable iff (rst)
    irqOut |-> ($past(pendingQ) & $past(irqEnQ)) != '0)
    else $error("interrupt without pending enabled line");
  irq_follow_a: assert property (@(posedge sysClk) disable iff (rst)
    ((pendingQ & irqEnQ) != '0) [*2] |=> irqOut)
    else $error("pending enabled line raised no interrupt");
  line_mask_a: assert property (@(posedge sysClk) disable iff (rst)
    ##1 ((lineIrq & ~$past(irqEnQ)) == '0))
    else $error("masked line drove its interrupt");
  evt_pass_a: assert property (@(posedge sysClk) disable iff (rst)
    ((edgeDet & evtEnQ) != '0) |=> (eventPulse == ($past(edgeDet) & $past(evtEnQ))))
    else $error("event pulse wrong for detected edge");
  bus_wait_a: assert property (@(posedge sysClk) disable iff (rst)
    ((read || write) && waitrequest) |=> !waitrequest ##1 waitrequest)
    else $error("waitrequest did not answer in one cycle");
  sel_range_a: assert property (@(posedge sysClk) disable iff (rst)
    (32'(pinSelQ[1]) >= NUM_PINS) |-> !lineSrc[1])
    else $error("out-of-range pin select drove line");
  // Pending bits appear only from a detected edge, never from the bus
  pend_cause_a: assert property (@(posedge sysClk) disable iff (rst)
    ##1 ((pendingQ & ~$past(pendingQ) & ~$past(edgeDet)) == '0))
    else $error("pending set without a detected edge");
  irq_mask_a: assert property (@(posedge sysClk) disable iff (rst)
    (irqEnQ == '0) |=> !irqOut)
    else $error("interrupt raised with every line masked");
  evt_mask_a: assert property (@(posedge sysClk) disable iff (rst)
    ##1 ((eventPulse & ~$past(evtEnQ)) == '0))
    else $error("masked line drove its event");
  bus_data_a: assert property (@(posedge sysClk) disable iff (rst)
    (read && waitrequest) |=> (readdata == $past(rdMux)))
    else $error("read data not loaded when request taken");

  cov_pend: cover property (@(posedge sysClk) disable iff (rst) $rose(pendingQ[0]));
  cov_irq: cover property (@(posedge sysClk) disable iff (rst) $rose(irqOut));
  cov_clear: cover property (@(posedge sysClk) disable iff (rst)
    rdAcc && address == eel_pkg::OFF_PEND && readdata != 32'h0000_0000);
  cov_evt: cover property (@(posedge sysClk) disable iff (rst) eventPulse != '0);
endmodule : eel_controller

// ===== testbench/eel_pin_model.sv
/* Partner model: general pins plus the three internal line sources.
   Assumes the bench calls its tasks; levels change asynchronously. */
`timescale 1ns/100ps
module eel_pin_model (
  output logic [50:0] gpioPins,
  output logic supplyLevelMonitor,
  output logic rtcAlarm,
  output logic usbWakeup
);
  // Bits 0..50 pins, 51 supply, 52 alarm, 53 wakeup
  logic [53:0] srcLvl = '0;
  assign {usbWakeup, rtcAlarm, supplyLevelMonitor, gpioPins} = srcLvl;
  task automatic setLevel(input int idx, input logic lvl);
    srcLvl[idx] = lvl;
  endtask : setLevel
  // Far shorter than a bus clock, unrelated to its phase
  task automatic glitch(input int idx);
    srcLvl[idx] = 1'b1;
    #3;
    srcLvl[idx] = 1'b0;
  endtask : glitch
endmodule : eel_pin_model

// ===== testbench/tb_edge_event_line_controller.sv
/* Self-checking bench for the edge event line controller.
   Assumes one 100 MHz clock and the pin model as line source. */
`timescale 1ns/100ps
module tb_edge_event_line_controller;
  logic sysClk, rst, read, write, waitrequest, irqOut;
  logic supplyLevelMonitor, rtcAlarm, usbWakeup;
  logic [eel_pkg::ADDR_W-1:0] address;
  logic [31:0] writedata, readdata, lfsr, expHead;
  logic [3:0] byteenable;
  logic [50:0] gpioPins;
  logic [18:0] lineIrq, eventPulse;
  logic [31:0] expQ[$];
  int errors = 0;
  int samples_checked = 0;
  int evtCnt;

  eel_pin_model PINS (.gpioPins(gpioPins), .supplyLevelMonitor(supplyLevelMonitor),
    .rtcAlarm(rtcAlarm), .usbWakeup(usbWakeup));
  eel_controller DUT (.sysClk(sysClk), .rst(rst), .gpioPins(gpioPins),
    .supplyLevelMonitor(supplyLevelMonitor), .rtcAlarm(rtcAlarm), .usbWakeup(usbWakeup),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .irqOut(irqOut), .lineIrq(lineIrq), .eventPulse(eventPulse));

  initial begin
    sysClk = 1'b0;
    forever #5 sysClk = ~sysClk;
  end

  function automatic logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nextRand

  task automatic end_sim();
    if (errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic check(input logic ok, input string what);
    samples_checked++;
    if (ok !== 1'b1) begin
      errors++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask : check

  // Holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sysClk);
    address <= a;
    read <= ~w;
    write <= w;
    writedata <= d;
    // Only the watchdog ends a wait that never finishes
    do begin
      @(posedge sysClk);
    end while (waitrequest !== 1'b0);
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask : rd

  // Read data taken at the edge where waitrequest is sampled low
  always @(posedge sysClk) begin
    if (read === 1'b1 && waitrequest === 1'b0 && expQ.size() > 0) begin
      expHead = expQ.pop_front();
      samples_checked++;
      if (readdata !== expHead) begin
        errors++;
        $display("[ERR] %0t read %h expected %h", $time, readdata, expHead);
      end
    end
  end

  initial begin
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = '0;
    writedata = '0;
    byteenable = 4'hF;
    lfsr = 32'h56d1;
    repeat (16) @(posedge sysClk);
    rst <= 1'b0;
    rd(eel_pkg::OFF_RISE, eel_pkg::RST_TRIG);
    rd(eel_pkg::OFF_IRQ_EN, eel_pkg::RST_MASK);
    rd(8'h14, 32'h0000_0000);
    for (int k = 0; k < 4; k++) begin
      lfsr = nextRand(lfsr);
      bus(1'b1, eel_pkg::OFF_EVT_EN, lfsr);
      rd(eel_pkg::OFF_EVT_EN, lfsr & 32'h0007_FFFF);
    end
    bus(1'b1, eel_pkg::OFF_EVT_EN, 32'h0000_0000);
    bus(1'b1, eel_pkg::OFF_SEL0, 32'h0000_FF32);
    rd(eel_pkg::OFF_SEL0, 32'h0000_3F32);
    bus(1'b1, eel_pkg::OFF_RISE, 32'h0000_0001);
    // Off the clock edge, so the new enable has settled
    @(negedge sysClk);
    PINS.glitch(50);
    repeat (6) @(posedge sysClk);
    rd(eel_pkg::OFF_PEND, 32'h0000_0001);
    rd(eel_pkg::OFF_PEND, 32'h0000_0000);
    bus(1'b1, eel_pkg::OFF_RISE, 32'h0004_0000);
    bus(1'b1, eel_pkg::OFF_FALL, 32'h0005_0000);
    bus(1'b1, eel_pkg::OFF_IRQ_EN, 32'h0001_0000);
    PINS.setLevel(51, 1'b1);
    PINS.setLevel(53, 1'b1);
    repeat (6) @(posedge sysClk);
    @(negedge sysClk);
    check(irqOut === 1'b0 && lineIrq === 19'h0_0000, "masked line raised irq");
    rd(eel_pkg::OFF_PEND, 32'h0004_0000);
    PINS.setLevel(51, 1'b0);
    PINS.setLevel(53, 1'b0);
    repeat (6) @(posedge sysClk);
    @(negedge sysClk);
    check(irqOut === 1'b1 && lineIrq === 19'h1_0000, "unmasked line silent");
    rd(eel_pkg::OFF_PEND, 32'h0005_0000);
    repeat (2) @(posedge sysClk);
    @(negedge sysClk);
    check(irqOut === 1'b0 && lineIrq === 19'h0_0000, "irq after clear");
    @(posedge sysClk);
    byteenable <= 4'h1;
    bus(1'b1, eel_pkg::OFF_RISE, 32'hFFFF_FFFF);
    byteenable <= 4'hF;
    rd(eel_pkg::OFF_RISE, 32'h0004_00FF);
    bus(1'b1, eel_pkg::OFF_RISE, 32'h0006_00FF);
    bus(1'b1, eel_pkg::OFF_EVT_EN, 32'h0002_0000);
    @(negedge sysClk);
    PINS.setLevel(52, 1'b1);
    evtCnt = 0;
    repeat (8) begin
      @(posedge sysClk);
      if (eventPulse === 19'h2_0000) begin
        evtCnt++;
      end else if (eventPulse !== 19'h0_0000) begin
        evtCnt += 100;
      end
    end
    check(evtCnt == 1, "event pulse not exactly one cycle");
    rd(eel_pkg::OFF_PEND, 32'h0002_0000);
    rst <= 1'b1;
    repeat (2) @(posedge sysClk);
    @(negedge sysClk);
    check(waitrequest === 1'b1 && readdata === 32'h0000_0000 && irqOut === 1'b0
      && eventPulse === 19'h0_0000, "outputs not at reset values");
    @(posedge sysClk);
    rst <= 1'b0;
    rd(eel_pkg::OFF_RISE, eel_pkg::RST_TRIG);
    rd(eel_pkg::OFF_PEND, 32'h0000_0000);
    repeat (2) @(posedge sysClk);
    end_sim();
  end

  // Whole run needs well under 1000 cycles
  initial begin
    repeat (20000) @(posedge sysClk);
    errors++;
    end_sim();
  end
endmodule : tb_edge_event_line_controller
